// ===== src/pes_pkg.sv
package pes_pkg;

    // Register map
    localparam logic [31:0] PES_SDN_CTRL_OFFSET = 32'h0000_0024;
    localparam logic [7:0] PES_SDN_CTRL_RESET = 8'h00;

    // Field positions of the shutdown control register
    localparam int PES_FLAG_BIT = 7;
    localparam int PES_IE_BIT = 6;
    localparam int PES_RESTART_BIT = 5;
    localparam int PES_LEVEL_BIT = 4;
    localparam int PES_UNUSED_BIT = 3;
    localparam int PES_STATUS_BIT = 2;
    localparam int PES_POL_BIT = 1;
    localparam int PES_ENA_BIT = 0;

    localparam int PES_NUM_CHANNELS = 8;

    // Least hold of the fault input, in bus clocks
    localparam int PES_MIN_FAULT_CYCLES = 2;

    typedef enum logic [1:0] {
        PES_RUN = 2'b00,
        PES_SHUT = 2'b01,
        PES_RELEASE = 2'b10
    } pes_state_type;

endpackage

// ===== src/pes_reg_if.sv
`timescale 1ns/1ps
interface pes_reg_if;
    logic wr_stb;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    modport slave (
        output wr_stb,
        output wr_data,
        input rd_data
    );
    modport core (
        input wr_stb,
        input wr_data,
        output rd_data
    );
endinterface

// ===== src/pes_fault_sync.sv
`timescale 1ns/1ps
module pes_fault_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    // First stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule

// ===== src/pes_ahb_slave.sv
`timescale 1ns/1ps
module pes_ahb_slave #(
    parameter logic [31:0] REG_ADDR = pes_pkg::PES_SDN_CTRL_OFFSET
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    pes_reg_if.slave regs
);
    import pes_pkg::*;

    logic wr_reg;
    logic wr_next;
    logic rd_reg;
    logic rd_next;
    logic hit_reg;
    logic hit_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic accept;

    assign accept = hsel & htrans[1] & hready;

    // Reads take one wait state so a write just before is seen
    always_comb begin
        wr_next = accept & hwrite;
        rd_next = accept & ~hwrite;
        hit_next = hit_reg;
        hrdata_next = hrdata_reg;
        if (accept) begin
            hit_next = (haddr[31:2] == REG_ADDR[31:2]);
        end
        if (rd_reg) begin
            hrdata_next = hit_reg ? {24'h00_0000, regs.rd_data} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            hit_reg <= 1'b0;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            hit_reg <= hit_next;
            hrdata_reg <= hrdata_next;
        end
    end

    assign regs.wr_stb = wr_reg & hit_reg;
    assign regs.wr_data = hwdata[7:0];
    assign hrdata = hrdata_reg;
    assign hreadyout = ~rd_reg;
    assign hresp = 1'b0;
endmodule

// ===== src/pes_top.sv
`timescale 1ns/1ps
// What this block does
// - Change flag sets on every active/passive change of the fault input.
// - Writing one clears the change flag; writing zero leaves it.
// - Interrupt request raised only while the interrupt enable bit is one.
// - Restart is accepted only while the fault input is not active.
// - After restart each channel resumes when its counter next hits zero.
// - After disabling the shutdown, channels still wait for counter zero.
// - Restart bit is a write event and always reads zero.
// - Active fault forces all enabled outputs to the programmed level.
// - Input status bit shows the current channel 7 pin state.
// - Polarity bit picks active low (0) or active high (1).
// - Enable bit turns channel 7 pin into input and arms shutdown.
// - Other bits act only while shutdown is enabled, except the status bit, the flag clear and the level on channels still held after disabling.
module pes_top #(
    parameter int N = pes_pkg::PES_NUM_CHANNELS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [N-1:0] pwm_raw,
    input wire logic [N-1:0] chan_enable,
    input wire logic [N-1:0] counter_zero,
    output logic [N-1:0] pwm_out,
    input wire logic ch7_pin_in,
    output logic ch7_pin_out,
    output logic ch7_pin_oe_n,
    output logic irq
);
    import pes_pkg::*;

    function automatic logic pes_is_active(input logic level, input logic pol);
        return level == pol;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    pes_reg_if u_regs ();

    pes_ahb_slave #(
        .REG_ADDR(PES_SDN_CTRL_OFFSET)
    ) u_slave (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .regs(u_regs.slave)
    );

    logic pin_level;

    pes_fault_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(ch7_pin_in),
        .sync_out(pin_level)
    );

    ////////////////////////////////////////////////////////////////////////
    logic ena_reg;
    logic ena_next;
    logic pol_reg;
    logic pol_next;
    logic lvl_reg;
    logic lvl_next;
    logic ie_reg;
    logic ie_next;
    logic flag_reg;
    logic flag_next;
    logic prev_pin_reg;
    logic prev_pin_next;
    logic active;
    logic change;
    logic wr;
    logic [7:0] wd;
    logic restart_req;

    assign wr = u_regs.wr_stb;
    assign wd = u_regs.wr_data;

    assign active = ena_reg & pes_is_active(pin_level, pol_reg);
    assign change = ena_reg & (pin_level != prev_pin_reg);
    assign restart_req = wr & wd[PES_RESTART_BIT] & ena_reg & ~active;

    always_comb begin
        ena_next = ena_reg;
        pol_next = pol_reg;
        lvl_next = lvl_reg;
        ie_next = ie_reg;
        flag_next = flag_reg;
        prev_pin_next = pin_level;
        if (wr) begin
            ena_next = wd[PES_ENA_BIT];
            pol_next = wd[PES_POL_BIT];
            lvl_next = wd[PES_LEVEL_BIT];
            ie_next = wd[PES_IE_BIT];
        end
        if (change) begin
            flag_next = 1'b1;
        end else if (wr && wd[PES_FLAG_BIT]) begin
            flag_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ena_reg <= PES_SDN_CTRL_RESET[PES_ENA_BIT];
            pol_reg <= PES_SDN_CTRL_RESET[PES_POL_BIT];
            lvl_reg <= PES_SDN_CTRL_RESET[PES_LEVEL_BIT];
            ie_reg <= PES_SDN_CTRL_RESET[PES_IE_BIT];
            flag_reg <= PES_SDN_CTRL_RESET[PES_FLAG_BIT];
            prev_pin_reg <= 1'b0;
        end else begin
            ena_reg <= ena_next;
            pol_reg <= pol_next;
            lvl_reg <= lvl_next;
            ie_reg <= ie_next;
            flag_reg <= flag_next;
            prev_pin_reg <= prev_pin_next;
        end
    end

    always_comb begin
        u_regs.rd_data = 8'h00;
        u_regs.rd_data[PES_FLAG_BIT] = flag_reg;
        u_regs.rd_data[PES_IE_BIT] = ie_reg;
        u_regs.rd_data[PES_LEVEL_BIT] = lvl_reg;
        u_regs.rd_data[PES_STATUS_BIT] = pin_level;
        u_regs.rd_data[PES_POL_BIT] = pol_reg;
        u_regs.rd_data[PES_ENA_BIT] = ena_reg;
    end

    assign irq = ena_reg & ie_reg & flag_reg;

    ////////////////////////////////////////////////////////////////////////
    pes_state_type state_reg;
    pes_state_type state_next;
    logic [N-1:0] hold_reg;
    logic [N-1:0] hold_next;
    logic [N-1:0] pwm_out_reg;
    logic [N-1:0] pwm_out_next;

    always_comb begin
        state_next = state_reg;
        hold_next = hold_reg;
        case (state_reg)
            PES_RUN: begin
                hold_next = '0;
                if (active) begin
                    state_next = PES_SHUT;
                    hold_next = '1;
                end
            end
            PES_SHUT: begin
                hold_next = '1;
                if (!ena_reg || restart_req) begin
                    state_next = PES_RELEASE;
                end
            end
            PES_RELEASE: begin
                if (active) begin
                    state_next = PES_SHUT;
                    hold_next = '1;
                end else begin
                    hold_next = hold_reg & ~counter_zero;
                    if (hold_next == '0) begin
                        state_next = PES_RUN;
                    end
                end
            end
            default: begin
                state_next = PES_RUN;
                hold_next = '0;
            end
        endcase
    end

    // force enabled channels to the level
    always_comb begin
        for (int i = 0; i < N; i++) begin
            pwm_out_next[i] = (hold_next[i] && chan_enable[i]) ? lvl_reg : pwm_raw[i];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= PES_RUN;
            hold_reg <= '0;
            pwm_out_reg <= '0;
        end else begin
            state_reg <= state_next;
            hold_reg <= hold_next;
            pwm_out_reg <= pwm_out_next;
        end
    end

    assign pwm_out = pwm_out_reg;
    assign ch7_pin_out = pwm_out_reg[N-1];
    // pin released to input while enabled
    assign ch7_pin_oe_n = ena_reg;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_flag_set;
        ena_reg && (pin_level != prev_pin_reg) |=> flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("change flag not set");

    property p_flag_clear;
        wr && wd[PES_FLAG_BIT] && !change |=> !flag_reg;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("change flag not cleared");

    property p_flag_keep;
        !change && !(wr && wd[PES_FLAG_BIT]) |=> flag_reg == $past(flag_reg);
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("change flag moved");

    property p_irq;
        (ena_reg && ie_reg && flag_reg) |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_restart_blocked;
        state_reg == PES_SHUT && active |=> state_reg == PES_SHUT;
    endproperty
    a_restart_blocked: assert property (p_restart_blocked) else $error("restart while active");

    property p_resume_zero;
        state_reg == PES_RELEASE && !active |=> hold_reg == ($past(hold_reg) & ~$past(counter_zero));
    endproperty
    a_resume_zero: assert property (p_resume_zero) else $error("channel resumed off zero");

    property p_disable_wait;
        state_reg == PES_SHUT && !ena_reg |=> state_reg == PES_RELEASE && hold_reg == '1;
    endproperty
    a_disable_wait: assert property (p_disable_wait) else $error("disable skipped zero wait");

    property p_restart_zero;
        hreadyout |-> hrdata[PES_RESTART_BIT] == 1'b0 && hrdata[PES_UNUSED_BIT] == 1'b0;
    endproperty
    a_restart_zero: assert property (p_restart_zero) else $error("restart or bit 3 read one");

    property p_force;
        active |=> ((pwm_out_reg ^ {N{$past(lvl_reg)}}) & $past(chan_enable)) == '0;
    endproperty
    a_force: assert property (p_force) else $error("output not forced");

    property p_status;
        ##2 1'b1 |-> pin_level == $past(ch7_pin_in, 2);
    endproperty
    a_status: assert property (p_status) else $error("status not the synced pin");

    property p_pin_input;
        ena_reg |-> ch7_pin_oe_n;
    endproperty
    a_pin_input: assert property (p_pin_input) else $error("pin driven while enabled");

    property p_disabled;
        !ena_reg |-> !irq && !active;
    endproperty
    a_disabled: assert property (p_disabled) else $error("effect while disabled");

    property p_irq_off;
        !(ena_reg && ie_reg && flag_reg) |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");

    property p_restart_release;
        state_reg == PES_SHUT && restart_req |=> state_reg == PES_RELEASE;
    endproperty
    a_restart_release: assert property (p_restart_release) else $error("restart not taken");

    // Reset in the antecedent: outputs are still cleared on the release edge
    property p_follow_raw;
        rst_n && state_reg == PES_RUN && !active |=> pwm_out_reg == $past(pwm_raw);
    endproperty
    a_follow_raw: assert property (p_follow_raw) else $error("output not raw while running");

    c_shutdown: cover property (state_reg == PES_RUN ##1 state_reg == PES_SHUT);
    c_release: cover property (state_reg == PES_RELEASE ##[1:50] state_reg == PES_RUN);
    c_flag_clear: cover property (flag_reg ##1 !flag_reg);
endmodule

// ===== verif/pes_fault_src.sv
`timescale 1ns/1ps
module pes_fault_src (
    input wire logic clk_sys,
    input wire logic fault_req,
    input wire logic act_high,
    output logic fault_pin
);
    logic [1:0] hold_reg = 2'h0;
    logic [1:0] hold_next;
    ////////////////////////////////////////////////////////////
    // hold two clocks
    always_comb begin
        hold_next = hold_reg;
        if (fault_req) begin
            hold_next = 2'h2;
        end else if (hold_reg != 2'h0) begin
            hold_next = hold_reg - 2'h1;
        end
    end
    always_ff @(posedge clk_sys) begin
        hold_reg <= hold_next;
    end
    // Passive level is driven, never left floating
    assign fault_pin = (hold_reg != 2'h0) ~^ act_high;
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    import pes_pkg::*;
    localparam logic [31:0] A = PES_SDN_CTRL_OFFSET;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] pwm_raw = 8'h5a;
    logic [7:0] chan_enable = 8'h0f;
    logic [7:0] counter_zero = 8'h00;
    logic fault_req = 1'b0;
    logic act_high = 1'b1;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic [7:0] pwm_out;
    logic hreadyout;
    logic hresp;
    logic ch7_pin_out;
    logic ch7_pin_oe_n;
    logic ch7_pin_in;
    logic irq;
    logic fault_pin;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    always #50 clk_sys = ~clk_sys;
    // Pin level resolved from both drivers
    assign ch7_pin_in = ch7_pin_oe_n ? fault_pin : ch7_pin_out;
    pes_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pwm_raw(pwm_raw), .chan_enable(chan_enable),
        .counter_zero(counter_zero), .pwm_out(pwm_out), .ch7_pin_in(ch7_pin_in),
        .ch7_pin_out(ch7_pin_out), .ch7_pin_oe_n(ch7_pin_oe_n), .irq(irq));
    pes_fault_src u_src (.clk_sys(clk_sys), .fault_req(fault_req), .act_high(act_high),
        .fault_pin(fault_pin));
    ////////////////////////////////////////////////////////////
    // Read at the edge itself, so the values are those the slave shows before it
    task automatic wait_rdy();
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
    endtask
    task automatic zero_pulse(input logic [7:0] m);
        counter_zero <= m;
        @(posedge clk_sys);
        counter_zero <= 8'h00;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(1'b0, A, 8'h00);
        `CHK(q, 32'h0)
        `CHK(pwm_out, 8'h5a)
        `CHK(ch7_pin_oe_n, 1'b0)
        bus(1'b1, A + 32'h4, 8'hff);
        bus(1'b0, A + 32'h4, 8'h00);
        `CHK(q, 32'h0)
        `CHK(hresp, 1'b0)
        $display("test reset done");
    endtask
    task automatic t_enable();
        bus(1'b1, A, 8'h2b);
        bus(1'b0, A, 8'h00);
        `CHK(q, 32'h03)
        `CHK(ch7_pin_oe_n, 1'b1)
        $display("test enable done");
    endtask
    task automatic t_shut();
        bus(1'b1, A, 8'h53);
        fault_req <= 1'b1;
        repeat (5) @(posedge clk_sys);
        `CHK(pwm_out, 8'h5f)
        bus(1'b0, A, 8'h00);
        `CHK(q, 32'hd7)
        `CHK(irq, 1'b1)
        bus(1'b1, A, 8'h73);
        bus(1'b0, A, 8'h00);
        `CHK(q, 32'hd7)
        fault_req <= 1'b0;
        // Zero counts while still held must not free anything
        counter_zero <= 8'hff;
        repeat (6) @(posedge clk_sys);
        counter_zero <= 8'h00;
        `CHK(pwm_out, 8'h5f)
        bus(1'b1, A, 8'hb3);
        `CHK(pwm_out, 8'h5f)
        bus(1'b0, A, 8'h00);
        `CHK(q, 32'h13)
        `CHK(irq, 1'b0)
        zero_pulse(8'h01);
        `CHK(pwm_out, 8'h5e)
        zero_pulse(8'hff);
        `CHK(pwm_out, 8'h5a)
        $display("test shutdown done");
    endtask
    task automatic t_disable();
        act_high <= 1'b0;
        bus(1'b1, A, 8'h01);
        repeat (4) @(posedge clk_sys);
        `CHK(pwm_out, 8'h5a)
        fault_req <= 1'b1;
        repeat (5) @(posedge clk_sys);
        `CHK(pwm_out, 8'h50)
        `CHK(irq, 1'b0)
        bus(1'b1, A, 8'h80);
        fault_req <= 1'b0;
        repeat (4) @(posedge clk_sys);
        `CHK(pwm_out, 8'h50)
        `CHK(ch7_pin_oe_n, 1'b0)
        bus(1'b0, A, 8'h00);
        `CHK(q, 32'h0)
        zero_pulse(8'hff);
        `CHK(pwm_out, 8'h5a)
        // Pin follows channel 7 while shutdown is off
        pwm_raw <= 8'hda;
        repeat (3) @(posedge clk_sys);
        `CHK(ch7_pin_out, 1'b1)
        bus(1'b0, A, 8'h00);
        `CHK(q, 32'h04)
        $display("test disable done");
    endtask
    ////////////////////////////////////////////////////////////
    // Whole run is under a hundred cycles; ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_enable();
        t_shut();
        t_disable();
        wrap_up();
    end
endmodule
